// File: rtl/odcc_pkg.sv
// Shared constants and types of the octal converter configuration control block
`default_nettype none

package odcc_pkg;

  // ********************************************************************
  // Geometry
  // ********************************************************************
  localparam int NUM_CH = 8;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 5;
  localparam int CH_W   = 3;

  // ********************************************************************
  // Register command codes (5-bit address)
  // ********************************************************************
  localparam logic [ADDR_W-1:0] ADDR_CONFIG = 5'h00;
  localparam logic [1:0]        KIND_CHAN   = 2'h1;  // 01ccc: channel data
  localparam logic [1:0]        KIND_ZERO   = 2'h2;  // 10ccc: zero register
  localparam logic [1:0]        KIND_GAIN   = 2'h3;  // 11ccc: gain register

  // ********************************************************************
  // Configuration register layout
  // ********************************************************************
  localparam int BIT_READBACK_SEL = 15;
  localparam int BIT_SYNC_LD      = 14;
  localparam int BIT_SOFT_RST     = 13;
  localparam int BIT_PD_A         = 12;
  localparam int BIT_PD_B         = 11;
  localparam int BIT_CAL_EN       = 10;

  localparam logic [DATA_W-1:0] CFG_RESET  = 16'h8000;
  localparam logic [DATA_W-1:0] CFG_WMASK  = 16'h9C00;  // Stored bits only
  localparam logic [DATA_W-1:0] GAIN_RESET = 16'h8000;
  localparam logic [DATA_W-1:0] ZERO_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] CODE_MAX   = 16'hFFFF;

  // Gain of 8000h is unity, so the product is scaled down by 15 bits
  localparam int GAIN_SHIFT = 15;

  // Synchroniser idle level of the active-low load pin
  localparam logic [1:0] PIN_SYNC_RESET = 2'h3;

  // ********************************************************************
  // Types
  // ********************************************************************
  typedef enum logic {ODCC_ENG_IDLE, ODCC_ENG_BUSY} odcc_eng_e;

endpackage : odcc_pkg

`default_nettype wire

// File: rtl/odcc_mem.sv
// Small single-port-write, registered-read memory for raw input data words
`default_nettype none

module odcc_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  // Clock
  input  wire logic             clk_sys,
  // Write port
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  // Read port
  input  wire logic             rd_en,
  input  wire logic [AW-1:0]    rd_addr,
  output var  logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  // No reset on the array; the owner tracks which entries hold valid data
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  // Read before write: a same-cycle write shows on the next read
  always_ff @(posedge clk_sys) begin
    if (rd_en) begin
      rd_data <= mem_q[rd_addr];
    end
  end

endmodule // odcc_mem

`default_nettype wire

// File: rtl/odcc_ctrl.sv
// Configuration, correction and output-latch control of an eight-channel converter
`default_nettype none

module odcc_ctrl
  import odcc_pkg::*;
(
  // Clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     arst_n,
  // Register access port
  input  wire logic                     reg_wr_en,
  input  wire logic                     reg_rd_en,
  input  wire logic [ADDR_W-1:0]        reg_addr,
  input  wire logic [DATA_W-1:0]        reg_wdata,
  output var  logic [DATA_W-1:0]        reg_rdata,
  output var  logic                     reg_rd_valid,
  // Load pin, active low, asynchronous to clk_sys
  input  wire logic                     async_latch_load_pin_n,
  // Converter side
  output var  logic [NUM_CH*DATA_W-1:0] latch_data,
  output var  logic [NUM_CH-1:0]        chan_output_hiz,
  output var  logic                     sync_latch_update_cmd
);
  // Internal state and decode nets
  logic [1:0]        pin_sync_reg;
  logic              pin_high, soft_rst_reg, cfg_wr, chan_wr, zero_wr, gain_wr, cal_en;
  logic              pend_cal_reg, ld_fire, load_now, rd_pend_reg, rd_in_valid_reg;
  logic [DATA_W-1:0] cfg_reg, cfg_rd, pend_raw_reg, eng_result, mem_rdata, rdata_next;
  logic [CH_W-1:0]   wr_ch, pend_ch_reg;
  logic [ADDR_W-1:0] rd_addr_reg;
  logic [NUM_CH-1:0] accessed_reg, in_valid_reg;
  odcc_eng_e         eng_state_reg;
  logic [DATA_W-1:0] chan_data_reg [NUM_CH], latch_reg [NUM_CH];
  logic [DATA_W-1:0] gain_reg [NUM_CH], zero_reg [NUM_CH];
  // ********************************************************************
  // Pin synchroniser and software reset
  // ********************************************************************
  // Two stages before anyone looks at the load pin
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pin_sync_reg <= PIN_SYNC_RESET;
    end else begin
      pin_sync_reg <= {pin_sync_reg[0], async_latch_load_pin_n};
    end
  end
  assign pin_high = pin_sync_reg[1];
  // One-cycle pulse; it clears itself because a high pulse masks its own next request
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      soft_rst_reg <= 1'b0;
    end else begin
      soft_rst_reg <= cfg_wr && reg_wdata[BIT_SOFT_RST] && !soft_rst_reg;
    end
  end
  // Write decode, shared by the register and the per-channel stores
  assign cfg_wr  = reg_wr_en && (reg_addr == ADDR_CONFIG);
  assign chan_wr = reg_wr_en && (reg_addr[ADDR_W-1 -: 2] == KIND_CHAN);
  assign zero_wr = reg_wr_en && (reg_addr[ADDR_W-1 -: 2] == KIND_ZERO);
  assign gain_wr = reg_wr_en && (reg_addr[ADDR_W-1 -: 2] == KIND_GAIN);
  assign wr_ch   = reg_addr[CH_W-1:0];
  assign cal_en  = cfg_reg[BIT_CAL_EN];

  // ********************************************************************
  // Configuration register
  // ********************************************************************
  // Only select, power-down and calibration bits are stored; bit 9 never is
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cfg_reg <= CFG_RESET;
    end else if (soft_rst_reg) begin
      cfg_reg <= CFG_RESET;
    end else if (cfg_wr) begin
      cfg_reg <= reg_wdata & CFG_WMASK;
    end
  end
  // Sync-load waits while the engine holds a word, so it never loads stale data
  assign ld_fire  = sync_latch_update_cmd && (eng_state_reg == ODCC_ENG_IDLE);
  assign load_now = ld_fire || !pin_high;
  // Command bit; a new request beats the clear of an old one
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sync_latch_update_cmd <= 1'b0;
    end else if (soft_rst_reg) begin
      sync_latch_update_cmd <= 1'b0;
    end else if (cfg_wr && reg_wdata[BIT_SYNC_LD] && pin_high) begin
      sync_latch_update_cmd <= 1'b1;
    end else if (load_now) begin
      sync_latch_update_cmd <= 1'b0;
    end
  end
  // Readback view: command bits show live state, reserved bits read 0
  always_comb begin
    cfg_rd               = cfg_reg;
    cfg_rd[BIT_SYNC_LD]  = sync_latch_update_cmd;
    cfg_rd[BIT_SOFT_RST] = soft_rst_reg;
  end

  // ********************************************************************
  // Correction engine
  // ********************************************************************
  // Every channel write outside a soft reset cycle takes one pass stage; correction applies only when enabled
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      eng_state_reg <= ODCC_ENG_IDLE;
      pend_ch_reg   <= '0;
      pend_raw_reg  <= DATA_RESET;
      pend_cal_reg  <= 1'b0;
    end else begin
      eng_state_reg <= (chan_wr && !soft_rst_reg) ? ODCC_ENG_BUSY : ODCC_ENG_IDLE; // Lost in soft reset
      if (chan_wr) begin
        pend_ch_reg  <= wr_ch;
        pend_raw_reg <= reg_wdata;
        pend_cal_reg <= cal_en;
      end
    end
  end
  // Unsigned gain product, signed zero, clamped to the code range
  always_comb begin
    logic [2*DATA_W-1:0] prod;
    logic signed [DATA_W+2:0] sum;
    prod = '0;
    sum  = '0;
    eng_result = pend_raw_reg;
    if (pend_cal_reg) begin
      prod = pend_raw_reg * gain_reg[pend_ch_reg];
      sum  = $signed({2'b00, prod[2*DATA_W-1:GAIN_SHIFT]})
           + $signed({{3{zero_reg[pend_ch_reg][DATA_W-1]}}, zero_reg[pend_ch_reg]});
      if (sum < 0) begin
        eng_result = DATA_RESET;
      end else if (sum > $signed({3'b000, CODE_MAX})) begin
        eng_result = CODE_MAX;
      end else begin
        eng_result = sum[DATA_W-1:0];
      end
    end
  end

  // ********************************************************************
  // Per-channel registers and latches
  // ********************************************************************
  for (genvar g = 0; g < NUM_CH; g++) begin : g_chan
    localparam logic [CH_W-1:0] CH = CH_W'(g);
    logic upd;
    assign upd = (eng_state_reg == ODCC_ENG_BUSY) && (pend_ch_reg == CH);
    // Channel data word holds the engine output, not the raw word
    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        chan_data_reg[g] <= DATA_RESET;
      end else if (soft_rst_reg) begin
        chan_data_reg[g] <= DATA_RESET;
      end else if (upd) begin
        chan_data_reg[g] <= eng_result;
      end
    end
    // Accessed mark; a fresh update survives a simultaneous load
    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        accessed_reg[g] <= 1'b0;
      end else if (soft_rst_reg) begin
        accessed_reg[g] <= 1'b0;
      end else if (upd) begin
        accessed_reg[g] <= 1'b1;
      end else if (load_now) begin
        accessed_reg[g] <= 1'b0;
      end
    end
    // Untouched channels keep their latch, avoiding needless glitches
    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        latch_reg[g] <= DATA_RESET;
      end else if (soft_rst_reg) begin
        latch_reg[g] <= DATA_RESET;
      end else if (load_now && accessed_reg[g]) begin
        latch_reg[g] <= chan_data_reg[g];
      end
    end
    assign latch_data[g*DATA_W +: DATA_W] = latch_reg[g];
    // Calibration coefficients
    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        gain_reg[g] <= GAIN_RESET;
        zero_reg[g] <= ZERO_RESET;
      end else if (soft_rst_reg) begin
        gain_reg[g] <= GAIN_RESET;
        zero_reg[g] <= ZERO_RESET;
      end else begin
        if (gain_wr && wr_ch == CH) begin
          gain_reg[g] <= reg_wdata;
        end
        if (zero_wr && wr_ch == CH) begin
          zero_reg[g] <= reg_wdata;
        end
      end
    end
    // Input word validity; the memory itself cannot be cleared by reset
    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        in_valid_reg[g] <= 1'b0;
      end else if (soft_rst_reg) begin
        in_valid_reg[g] <= 1'b0;
      end else if (chan_wr && wr_ch == CH) begin
        in_valid_reg[g] <= 1'b1;
      end
    end
    // Power-down groups: lower half is group A, upper half group B; a soft reset clears at once
    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        chan_output_hiz[g] <= 1'b0;
      end else begin
        chan_output_hiz[g] <= !soft_rst_reg && cfg_reg[(g < NUM_CH / 2) ? BIT_PD_A : BIT_PD_B];
      end
    end
  end

  // ********************************************************************
  // Raw input store and readback
  // ********************************************************************
  odcc_mem #(
    .WIDTH (DATA_W),
    .DEPTH (NUM_CH),
    .AW    (CH_W)
  ) u_in_mem (
    .clk_sys (clk_sys),
    .wr_en   (chan_wr),
    .wr_addr (wr_ch),
    .wr_data (reg_wdata),
    .rd_en   (reg_rd_en),
    .rd_addr (reg_addr[CH_W-1:0]),
    .rd_data (mem_rdata)
  );
  // Stage one: address capture while the memory reads
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rd_pend_reg     <= 1'b0;
      rd_addr_reg     <= '0;
      rd_in_valid_reg <= 1'b0;
    end else begin
      rd_pend_reg <= reg_rd_en && !soft_rst_reg; // A read in the soft reset cycle is lost
      if (reg_rd_en) begin
        rd_addr_reg     <= reg_addr;
        rd_in_valid_reg <= in_valid_reg[reg_addr[CH_W-1:0]];
      end
    end
  end
  // Stage two: select the answer; unmapped codes read 0
  always_comb begin
    rdata_next = '0;
    if (rd_addr_reg == ADDR_CONFIG) begin
      rdata_next = cfg_rd;
    end else if (rd_addr_reg[ADDR_W-1 -: 2] == KIND_CHAN) begin
      if (cfg_reg[BIT_READBACK_SEL]) begin
        rdata_next = chan_data_reg[rd_addr_reg[CH_W-1:0]];
      end else if (rd_in_valid_reg) begin
        rdata_next = mem_rdata;
      end
    end else if (rd_addr_reg[ADDR_W-1 -: 2] == KIND_ZERO) begin
      rdata_next = zero_reg[rd_addr_reg[CH_W-1:0]];
    end else if (rd_addr_reg[ADDR_W-1 -: 2] == KIND_GAIN) begin
      rdata_next = gain_reg[rd_addr_reg[CH_W-1:0]];
    end
  end
  // Answer registers
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata    <= '0;
      reg_rd_valid <= 1'b0;
    end else if (soft_rst_reg) begin
      reg_rdata    <= '0;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= rd_pend_reg;
      if (rd_pend_reg) begin
        reg_rdata <= rdata_next;
      end
    end
  end
endmodule // odcc_ctrl

`default_nettype wire

// File: bench/odcc_ctrl_asserts.sv
// Port-level checks of the configuration control block
`default_nettype none

module odcc_ctrl_asserts
  import odcc_pkg::*;
(
  // Clock and reset
  input wire logic                     clk_sys,
  input wire logic                     arst_n,
  // Register access
  input wire logic                     reg_wr_en,
  input wire logic                     reg_rd_en,
  input wire logic [ADDR_W-1:0]        reg_addr,
  input wire logic [DATA_W-1:0]        reg_wdata,
  input wire logic                     reg_rd_valid,
  // Load pin and converter side
  input wire logic                     async_latch_load_pin_n,
  input wire logic [NUM_CH*DATA_W-1:0] latch_data,
  input wire logic [NUM_CH-1:0]        chan_output_hiz,
  input wire logic                     sync_latch_update_cmd
);
  timeunit 1ns;
  timeprecision 1ps;

  logic       cfg_wr;
  logic       soft_wr;
  logic [5:0] pin_low_hist;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  // Config write decode, soft reset excluded where it would mask the effect
  assign cfg_wr  = reg_wr_en && (reg_addr == ADDR_CONFIG);
  assign soft_wr = cfg_wr && reg_wdata[BIT_SOFT_RST];

  // Raw pin history; the synchroniser delays a pin load by a few cycles
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pin_low_hist <= 6'h00;
    end else begin
      pin_low_hist <= {pin_low_hist[4:0], ~async_latch_load_pin_n};
    end
  end

  // ********************************************************************
  // Assertions
  // ********************************************************************
  chk_rd_latency: assert property (reg_rd_en |-> ##2 reg_rd_valid)
    else $error("read answer not two cycles after request");
  chk_rd_cause: assert property (reg_rd_valid |-> $past(reg_rd_en, 2))
    else $error("read answer without a request");
  chk_cmd_cause: assert property ($rose(sync_latch_update_cmd) |-> $past(cfg_wr && reg_wdata[BIT_SYNC_LD]))
    else $error("sync load pending without a command write");
  chk_cmd_self_clear: assert property (sync_latch_update_cmd |-> ##[1:3] !sync_latch_update_cmd)
    else $error("sync load bit did not clear");
  chk_cmd_pin_low: assert property ((!async_latch_load_pin_n) [*4] |-> !sync_latch_update_cmd)
    else $error("sync load held while load pin low");
  chk_latch_cause: assert property (!$stable(latch_data) |->
    $past(sync_latch_update_cmd) || $past(soft_wr, 2) || (|pin_low_hist[4:1]))
    else $error("latch changed without a load");
  chk_hiz_group_a: assert property (cfg_wr && !reg_wdata[BIT_SOFT_RST] && reg_wdata[BIT_PD_A]
    |-> ##[1:2] chan_output_hiz[3:0] == 4'hF)
    else $error("group A not powered down");
  chk_hiz_group_b: assert property (cfg_wr && !reg_wdata[BIT_SOFT_RST] && !reg_wdata[BIT_PD_B]
    |-> ##[1:2] chan_output_hiz[7:4] == 4'h0)
    else $error("group B not restored");

endmodule // odcc_ctrl_asserts

`default_nettype wire

// File: bench/odcc_host_model.sv
// Behavioural host issuing register requests and driving the load pin
`default_nettype none

module odcc_host_model
  import odcc_pkg::*;
(
  // Clock
  input  wire logic              clk_sys,
  // Register requests
  output var  logic              reg_wr_en,
  output var  logic              reg_rd_en,
  output var  logic [ADDR_W-1:0] reg_addr,
  output var  logic [DATA_W-1:0] reg_wdata,
  // Load pin
  output var  logic              async_latch_load_pin_n
);
  timeunit 1ns;
  timeprecision 1ps;

  int unsigned gap = 0;  // Extra idle cycles per request; raised for a slow host

  // Idle levels at time zero
  initial begin
    reg_wr_en              = 1'b0;
    reg_rd_en              = 1'b0;
    reg_addr               = 5'h00;
    reg_wdata              = 16'h0000;
    async_latch_load_pin_n = 1'b1;
  end

  // One request per call; released lines show the inverse so stale data never looks valid
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge clk_sys);
    reg_wr_en = wr;
    reg_rd_en = ~wr;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
    repeat (gap) @(negedge clk_sys);
  endtask

  // Pin moves on a falling edge, unrelated to any request
  task automatic set_pin(input logic v);
    @(negedge clk_sys);
    async_latch_load_pin_n = v;
  endtask

endmodule // odcc_host_model

`default_nettype wire

// File: bench/odcc_ctrl_tb_top.sv
// Self-checking bench of the configuration control block
`default_nettype none

module odcc_ctrl_tb_top import odcc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic                     clk_sys = 1'b0;
  logic                     arst_n  = 1'b0;
  logic                     reg_wr_en, reg_rd_en, reg_rd_valid, pin_n, cmd;
  logic [ADDR_W-1:0]        reg_addr;
  logic [DATA_W-1:0]        reg_wdata, reg_rdata;
  logic [NUM_CH*DATA_W-1:0] latch_data;
  logic [NUM_CH-1:0]        hiz;
  logic [DATA_W-1:0]        exp_q[$];
  logic [DATA_W-1:0]        val[NUM_CH];
  int                       n_fail = 0;
  int                       check_count = 0;
  int                       seed = 10704;

  always #4 clk_sys = ~clk_sys;

  odcc_host_model host_inst (.clk_sys(clk_sys), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .async_latch_load_pin_n(pin_n));
  odcc_ctrl odcc_ctrl_inst (.clk_sys(clk_sys), .arst_n(arst_n), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .async_latch_load_pin_n(pin_n), .latch_data(latch_data),
    .chan_output_hiz(hiz), .sync_latch_update_cmd(cmd));

  // ********************************************************************
  // Checking tasks
  // ********************************************************************
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    host_inst.access(1'b1, a, d);
  endtask

  // The expectation is queued before the request goes out
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    exp_q.push_back(e);
    host_inst.access(1'b0, a, 16'h0000);
  endtask

  // Drain outstanding answers under a bound, let loads and power-down settle, then vary host speed
  task automatic test_end(input string name);
    for (int i = 0; i < 40 && exp_q.size() != 0; i++) begin
      @(negedge clk_sys);
    end
    repeat (4) @(negedge clk_sys);
    if (exp_q.size() != 0) begin
      n_fail++;
      $display("Error at %0t: read answers missing", $time);
      report_and_stop();
    end
    $display("test %0s done", name);
    host_inst.gap = 32'($random(seed)) & 3;
  endtask

  // Answer watcher: each valid pulse consumes the oldest expectation
  always @(negedge clk_sys) begin
    if (reg_rd_valid === 1'b1) begin
      check(reg_rdata, (exp_q.size() != 0) ? exp_q.pop_front() : 16'hXXXX);
    end
  end

  // Main sequence
  initial begin
    logic [DATA_W-1:0] d;
    repeat (10) @(negedge clk_sys);
    arst_n = 1'b1;
    rd(ADDR_CONFIG, CFG_RESET);
    rd(5'h05, 16'h0000);
    for (int c = 0; c < NUM_CH; c++) begin
      rd({KIND_GAIN, c[2:0]}, 16'h8000);
      rd({KIND_ZERO, c[2:0]}, 16'h0000);
    end
    test_end("reset");
    wr(ADDR_CONFIG, 16'hDEFF);
    rd(ADDR_CONFIG, 16'h9C00);
    test_end("config bits");
    check({8'h00, hiz}, 16'h00FF);
    wr(ADDR_CONFIG, 16'h0800);
    rd(ADDR_CONFIG, 16'h0800);
    test_end("group b down");
    check({8'h00, hiz}, 16'h00F0);
    wr(ADDR_CONFIG, 16'h1000);
    test_end("group a down");
    check({8'h00, hiz}, 16'h000F);
    wr(ADDR_CONFIG, 16'h0000);
    for (int c = 0; c < NUM_CH; c++) begin
      val[c] = 16'($random(seed));
      wr({KIND_CHAN, c[2:0]}, val[c]);
    end
    for (int c = 0; c < NUM_CH; c++) begin
      rd({KIND_CHAN, c[2:0]}, val[c]);
      check(latch_data[c*DATA_W +: DATA_W], 16'h0000);
    end
    wr(ADDR_CONFIG, 16'h8000);
    for (int c = 0; c < NUM_CH; c++) begin
      rd({KIND_CHAN, c[2:0]}, val[c]);
    end
    wr(ADDR_CONFIG, 16'hC000);
    rd(ADDR_CONFIG, 16'h8000);
    test_end("sync load all");
    for (int c = 0; c < NUM_CH; c++) begin
      check(latch_data[c*DATA_W +: DATA_W], val[c]);
    end
    d = 16'($random(seed));
    wr({KIND_CHAN, 3'h2}, d);
    wr(ADDR_CONFIG, 16'hC000);
    test_end("partial load");
    val[2] = d;
    for (int c = 0; c < NUM_CH; c++) begin
      check(latch_data[c*DATA_W +: DATA_W], val[c]);
    end
    host_inst.set_pin(1'b0);
    d = 16'($random(seed));
    wr({KIND_CHAN, 3'h5}, d);
    wr(ADDR_CONFIG, 16'hC000);
    rd(ADDR_CONFIG, 16'h8000);
    test_end("pin load");
    check(latch_data[5*DATA_W +: DATA_W], d);
    host_inst.set_pin(1'b1);
    wr(ADDR_CONFIG, 16'h8400);
    wr({KIND_GAIN, 3'h1}, 16'h4000);
    wr({KIND_ZERO, 3'h1}, 16'hFFF0);
    wr({KIND_GAIN, 3'h3}, 16'hFFFF);
    wr({KIND_CHAN, 3'h1}, 16'h1000);
    wr({KIND_CHAN, 3'h3}, 16'h4000);
    rd({KIND_CHAN, 3'h1}, 16'h07F0);
    rd({KIND_CHAN, 3'h3}, 16'h7FFF);
    wr(ADDR_CONFIG, 16'h0400);
    rd({KIND_CHAN, 3'h1}, 16'h1000);
    wr(ADDR_CONFIG, 16'h4400);
    test_end("correction");
    check(latch_data[1*DATA_W +: DATA_W], 16'h07F0);
    check(latch_data[3*DATA_W +: DATA_W], 16'h7FFF);
    wr(ADDR_CONFIG, 16'h3800);
    rd(ADDR_CONFIG, CFG_RESET);
    rd({KIND_GAIN, 3'h1}, 16'h8000);
    test_end("soft reset");
    check({8'h00, hiz}, 16'h0000);
    check(latch_data[1*DATA_W +: DATA_W], 16'h0000);
    report_and_stop();
  end

endmodule // odcc_ctrl_tb_top

bind odcc_ctrl odcc_ctrl_asserts odcc_ctrl_asserts_inst (.clk_sys(clk_sys), .arst_n(arst_n),
  .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rd_valid(reg_rd_valid), .async_latch_load_pin_n(async_latch_load_pin_n),
  .latch_data(latch_data), .chan_output_hiz(chan_output_hiz),
  .sync_latch_update_cmd(sync_latch_update_cmd));

`default_nettype wire
